/* File: hdl/alarm_codeword_pkg.sv */
package alarm_codeword_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h60;
  localparam logic [7:0] IDX_LIVE = 8'h61;
  localparam logic [7:0] IDX_LATCHED = 8'h62;
  localparam logic [7:0] IDX_IRQ_EN = 8'h63;
  localparam logic [7:0] IDX_TX_FIRST = 8'h64;
  localparam logic [7:0] IDX_TX_SECOND = 8'h65;
  localparam logic [7:0] IDX_RX_FIFO = 8'h66;
  localparam logic [7:0] IDX_BLOCK_IRQ_EN = 8'h67;

  // Control field positions
  localparam int CTL_SEL_LSB = 0;
  localparam int CTL_RX_RESET_BIT = 2;

  // Live status positions
  localparam int LIVE_TX_IDLE = 0;
  localparam int LIVE_RX_DET = 1;
  localparam int LIVE_RX_IDLE = 2;
  localparam int LIVE_RX_EMPTY = 3;

  // Latched status and enable positions
  localparam int LAT_TX_IDLE = 0;
  localparam int LAT_RX_DET = 1;
  localparam int LAT_RX_IDLE = 2;
  localparam int LAT_NOT_EMPTY = 3;
  localparam int LAT_OVERFLOW = 4;

  // Reset values
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [4:0] IRQ_EN_RESET = 5'h00;
  localparam logic [5:0] TX_WORD_RESET = 6'h00;
  localparam logic [3:0] LIVE_PREV_RESET = 4'h9;

  // Transmit select codes
  localparam logic [1:0] SEL_IDLE = 2'h0;
  localparam logic [1:0] SEL_ONCE = 2'h1;
  localparam logic [1:0] SEL_PAIR = 2'h2;
  localparam logic [1:0] SEL_CONT = 2'h3;
  localparam logic [1:0] NSEL_ALARM_TX = 2'h2;

  // Counts
  localparam logic [3:0] TX_REPEATS = 4'ha;
  localparam logic [3:0] WORD_LAST_BIT = 4'hf;
  localparam logic [1:0] RX_VALIDATE = 2'h3;
  localparam logic [1:0] RX_DIFF_CLEAR = 2'h2;
  localparam logic [4:0] RX_IDLE_ONES = 5'h10;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_ONCE = 3'b001,
    TX_PAIR_A = 3'b010,
    TX_PAIR_B = 3'b011,
    TX_CONT = 3'b100
  } tx_state_t;

endpackage : alarm_codeword_pkg

/* File: hdl/far_end_alarm_codeword_ctrl.sv */
// Function
// - Codeword: eight ones, zero, six bits, zero
// - C-bit parity mode uses alarm C-bit both ways
// - E3 receiver always listens to national bit
// - E3 transmit drives national bit only when selected
// - Block inactive in M23 framing mode
// - Idle transmitter sends continuous ones
// - Select codes: idle, A×10, A×10+B×10, A until zero
// - Action starts on select change from zero
// - Ten-count actions finish even if deselected
// - Continuous sends ten minimum, stops on zero
// - Bitwise search, three identical codewords validate
// - Validation raises detected and pushes payload
// - Receive FIFO holds four entries
// - Full FIFO drops codeword, sets overflow latch
// - Detected clears after two differing codewords
// - Rising receive reset bit clears receiver, FIFO
// - Receive idle on sixteen ones, cleared on validation
// - Empty status reflects FIFO holding nothing
// - Transmit idle high while ones are sent
// - Latches set on status edges, write-one clears
// - Interrupt needs latch, own enable, block enable
// - Overflow latch sets on lost codeword only
// - Transmit payload sent least significant first
// - Receive payload first bit is LSB
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps

module far_end_alarm_codeword_ctrl
  import alarm_codeword_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic ds3_mode_i,
  input wire logic cbit_parity_i,
  input wire logic [1:0] national_bit_source_sel_i,
  input wire logic tx_slot_i,
  output logic tx_alarm_bit_o,
  output logic tx_alarm_drive_o,
  input wire logic rx_slot_i,
  input wire logic rx_alarm_bit_i,
  output logic alarm_irq_o
);

  typedef struct packed {
    logic [1:0] tx_action_select;
    logic rx_codeword_reset;
    logic [1:0] sel_prev;
    logic rx_reset_prev;
    logic [4:0] irq_en;
    logic alarm_block_irq_en;
    logic [5:0] tx_first_codeword_bits;
    logic [5:0] tx_second_codeword_bits;
    tx_state_t tx_state;
    logic [3:0] tx_bit_cnt;
    logic [3:0] tx_word_cnt;
    logic tx_bit;
    logic tx_drive;
    logic [15:0] rx_sr;
    logic rx_locked;
    logic [3:0] rx_pos;
    logic [5:0] rx_cand;
    logic [1:0] rx_match_cnt;
    logic [5:0] rx_det_word;
    logic [1:0] rx_diff_cnt;
    logic [4:0] rx_ones;
    logic rx_detected;
    logic rx_idle;
    logic [3:0][5:0] fifo;
    logic [1:0] rd_ptr;
    logic [1:0] wr_ptr;
    logic [2:0] count;
    logic [4:0] latched;
    logic [3:0] live_prev;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic ready;
    logic irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Builds the 16-bit codeword, bit 0 sent first
  function automatic logic [15:0] make_word(input logic [5:0] payload);
    make_word = {1'b0, payload, 1'b0, 8'hff};
  endfunction : make_word

  // Checks a received window, oldest bit in bit 0
  function automatic logic is_word(input logic [15:0] w);
    is_word = (w[7:0] == 8'hff) && !w[8] && !w[15];
  endfunction : is_word

  logic e3_mode;
  logic cbit_mode;
  logic [3:0] live;
  logic [7:0] rd_idx;
  logic take;
  logic pop;
  logic push;
  logic overflow;
  logic [15:0] sr_next;
  logic opp;
  logic [5:0] rx_pay;
  logic validate;
  logic [4:0] events;
  logic [5:0] tx_pay;
  logic [3:0] wc;
  logic [15:0] tx_word;
  logic [7:0] wdata;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    e3_mode = !ds3_mode_i;
    cbit_mode = ds3_mode_i && cbit_parity_i;
    live = {s_q.count == 3'h0, s_q.rx_idle, s_q.rx_detected, s_q.tx_state == TX_IDLE};
    wdata = hwdata_i[7:0];
    push = 1'b0;
    overflow = 1'b0;
    validate = 1'b0;
    opp = 1'b0;
    rx_pay = 6'h00;
    sr_next = s_q.rx_sr;
    tx_pay = 6'h00;
    wc = 4'h0;
    tx_word = 16'hffff;

    // Bus: address phase
    take = hsel_i && hready_i && htrans_i[1];
    rd_idx = haddr_i[9:2];
    pop = 1'b0;
    s_d.wr_pend = take && hwrite_i;
    s_d.wr_idx = rd_idx;
    s_d.ready = 1'b1;
    if (take && !hwrite_i) begin
      unique case (rd_idx)
        IDX_CONTROL: s_d.rdata = {29'h0, s_q.rx_codeword_reset, s_q.tx_action_select};
        IDX_LIVE: s_d.rdata = {28'h0, live};
        IDX_LATCHED: s_d.rdata = {27'h0, s_q.latched};
        IDX_IRQ_EN: s_d.rdata = {27'h0, s_q.irq_en};
        IDX_TX_FIRST: s_d.rdata = {26'h0, s_q.tx_first_codeword_bits};
        IDX_TX_SECOND: s_d.rdata = {26'h0, s_q.tx_second_codeword_bits};
        IDX_RX_FIFO: begin
          s_d.rdata = (s_q.count == 3'h0) ? 32'h0 : {26'h0, s_q.fifo[s_q.rd_ptr]};
          pop = s_q.count != 3'h0;
        end
        IDX_BLOCK_IRQ_EN: s_d.rdata = {31'h0, s_q.alarm_block_irq_en};
        default: s_d.rdata = 32'h0;
      endcase
    end

    // Bus: data phase write
    if (s_q.wr_pend) begin
      unique case (s_q.wr_idx)
        IDX_CONTROL: begin
          s_d.tx_action_select = wdata[CTL_SEL_LSB +: 2];
          s_d.rx_codeword_reset = wdata[CTL_RX_RESET_BIT];
        end
        IDX_IRQ_EN: s_d.irq_en = wdata[4:0];
        IDX_TX_FIRST: s_d.tx_first_codeword_bits = wdata[5:0];
        IDX_TX_SECOND: s_d.tx_second_codeword_bits = wdata[5:0];
        IDX_BLOCK_IRQ_EN: s_d.alarm_block_irq_en = wdata[0];
        default: ;
      endcase
    end
    s_d.sel_prev = s_q.tx_action_select;
    s_d.rx_reset_prev = s_q.rx_codeword_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter
    s_d.tx_drive = cbit_mode || (e3_mode && national_bit_source_sel_i == NSEL_ALARM_TX);
    if (ds3_mode_i && !cbit_mode) begin
      s_d.tx_state = TX_IDLE;
      s_d.tx_bit = 1'b1;
      s_d.tx_drive = 1'b0;
    end else if (s_q.tx_state == TX_IDLE) begin
      s_d.tx_bit = 1'b1;
      if (s_q.sel_prev == SEL_IDLE && s_q.tx_action_select != SEL_IDLE) begin
        unique case (s_q.tx_action_select)
          SEL_ONCE: s_d.tx_state = TX_ONCE;
          SEL_PAIR: s_d.tx_state = TX_PAIR_A;
          default: s_d.tx_state = TX_CONT;
        endcase
        s_d.tx_bit_cnt = 4'h0;
        s_d.tx_word_cnt = 4'h0;
        tx_word = make_word(s_q.tx_first_codeword_bits);
        s_d.tx_bit = tx_word[0];
      end
    end else if (tx_slot_i) begin
      s_d.tx_bit_cnt = s_q.tx_bit_cnt + 4'h1;
      if (s_q.tx_bit_cnt == WORD_LAST_BIT) begin
        wc = (s_q.tx_word_cnt == TX_REPEATS) ? TX_REPEATS : s_q.tx_word_cnt + 4'h1;
        s_d.tx_word_cnt = wc;
        unique case (s_q.tx_state)
          TX_ONCE: if (wc == TX_REPEATS) s_d.tx_state = TX_IDLE;
          TX_PAIR_A: if (wc == TX_REPEATS) begin
            s_d.tx_state = TX_PAIR_B;
            s_d.tx_word_cnt = 4'h0;
          end
          TX_PAIR_B: if (wc == TX_REPEATS) s_d.tx_state = TX_IDLE;
          default: if (wc == TX_REPEATS && s_q.tx_action_select == SEL_IDLE) begin
            s_d.tx_state = TX_IDLE;
          end
        endcase
      end
      tx_pay = (s_d.tx_state == TX_PAIR_B) ? s_q.tx_second_codeword_bits
                                           : s_q.tx_first_codeword_bits;
      tx_word = make_word(tx_pay);
      s_d.tx_bit = (s_d.tx_state == TX_IDLE) ? 1'b1 : tx_word[s_d.tx_bit_cnt];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver
    if (rx_slot_i && (cbit_mode || e3_mode)) begin
      sr_next = {rx_alarm_bit_i, s_q.rx_sr[15:1]};
      s_d.rx_sr = sr_next;
      s_d.rx_pos = s_q.rx_pos + 4'h1;
      rx_pay = sr_next[14:9];
      s_d.rx_ones = !rx_alarm_bit_i ? 5'h00 :
                    (s_q.rx_ones == RX_IDLE_ONES) ? RX_IDLE_ONES : s_q.rx_ones + 5'h01;
      if (s_d.rx_ones == RX_IDLE_ONES) s_d.rx_idle = 1'b1;
      if (s_q.rx_locked) begin
        if (s_q.rx_pos == WORD_LAST_BIT) begin
          opp = 1'b1;
          s_d.rx_pos = 4'h0;
          if (!is_word(sr_next)) begin
            s_d.rx_locked = 1'b0;
            s_d.rx_match_cnt = 2'h0;
          end
        end
      end else if (is_word(sr_next)) begin
        opp = 1'b1;
        s_d.rx_locked = 1'b1;
        s_d.rx_pos = 4'h0;
      end
      if (opp) begin
        if (is_word(sr_next)) begin
          if (s_q.rx_match_cnt != 2'h0 && rx_pay == s_q.rx_cand) begin
            if (s_q.rx_match_cnt != RX_VALIDATE) s_d.rx_match_cnt = s_q.rx_match_cnt + 2'h1;
            validate = s_q.rx_match_cnt == RX_VALIDATE - 2'h1;
          end else begin
            s_d.rx_cand = rx_pay;
            s_d.rx_match_cnt = 2'h1;
          end
        end
        if (is_word(sr_next) && rx_pay == s_q.rx_det_word) begin
          s_d.rx_diff_cnt = 2'h0;
        end else if (s_q.rx_diff_cnt == RX_DIFF_CLEAR - 2'h1) begin
          s_d.rx_diff_cnt = 2'h0;
          s_d.rx_detected = 1'b0;
        end else begin
          s_d.rx_diff_cnt = s_q.rx_diff_cnt + 2'h1;
        end
      end
      if (validate) begin
        s_d.rx_detected = 1'b1;
        s_d.rx_det_word = rx_pay;
        s_d.rx_diff_cnt = 2'h0;
        s_d.rx_idle = 1'b0;
        push = 1'b1;
      end
    end

    // Receive FIFO
    overflow = push && s_q.count == FIFO_DEPTH && !pop;
    if (push && !overflow) begin
      s_d.fifo[s_q.wr_ptr] = rx_pay;
      s_d.wr_ptr = s_q.wr_ptr + 2'h1;
    end
    if (pop) s_d.rd_ptr = s_q.rd_ptr + 2'h1;
    s_d.count = s_q.count + {2'h0, push && !overflow} - {2'h0, pop};

    if (s_q.rx_codeword_reset && !s_q.rx_reset_prev) begin
      s_d.rx_sr = 16'h0;
      s_d.rx_locked = 1'b0;
      s_d.rx_pos = 4'h0;
      s_d.rx_match_cnt = 2'h0;
      s_d.rx_diff_cnt = 2'h0;
      s_d.rx_ones = 5'h00;
      s_d.rx_detected = 1'b0;
      s_d.rx_idle = 1'b0;
      s_d.rd_ptr = 2'h0;
      s_d.wr_ptr = 2'h0;
      s_d.count = 3'h0;
      overflow = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latched status and interrupt
    events = 5'h00;
    events[LAT_TX_IDLE] = live[LIVE_TX_IDLE] && !s_q.live_prev[LIVE_TX_IDLE];
    events[LAT_RX_DET] = live[LIVE_RX_DET] && !s_q.live_prev[LIVE_RX_DET];
    events[LAT_RX_IDLE] = live[LIVE_RX_IDLE] && !s_q.live_prev[LIVE_RX_IDLE];
    events[LAT_NOT_EMPTY] = !live[LIVE_RX_EMPTY] && s_q.live_prev[LIVE_RX_EMPTY];
    events[LAT_OVERFLOW] = overflow;
    s_d.live_prev = live;
    if (s_q.wr_pend && s_q.wr_idx == IDX_LATCHED) begin
      s_d.latched = s_q.latched & ~wdata[4:0];
    end
    s_d.latched = s_d.latched | events;
    s_d.irq = s_d.alarm_block_irq_en && |(s_d.latched & s_d.irq_en);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.tx_action_select <= SEL_RESET;
      s_q.irq_en <= IRQ_EN_RESET;
      s_q.tx_first_codeword_bits <= TX_WORD_RESET;
      s_q.tx_second_codeword_bits <= TX_WORD_RESET;
      s_q.tx_state <= TX_IDLE;
      s_q.tx_bit <= 1'b1;
      s_q.live_prev <= LIVE_PREV_RESET;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata_o = s_q.rdata;
  assign hreadyout_o = s_q.ready;
  assign hresp_o = 1'b0;
  assign tx_alarm_bit_o = s_q.tx_bit;
  assign tx_alarm_drive_o = s_q.tx_drive;
  assign alarm_irq_o = s_q.irq;

endmodule : far_end_alarm_codeword_ctrl

/* File: test/alarm_codeword_assertions.sv */
`timescale 1ns/1ps
module alarm_codeword_assertions
  import alarm_codeword_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic ds3_mode_i,
  input wire logic cbit_parity_i,
  input wire logic [1:0] national_bit_source_sel_i,
  input wire logic tx_slot_i,
  input wire logic tx_alarm_bit_o,
  input wire logic tx_alarm_drive_o,
  input wire logic alarm_irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic wr_q;
  logic rd_q;
  logic [7:0] idx_q;
  ////////////////////////////////////////////////////////////////
  // Data phase tracking
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 8'h00;
    end else if (hready_i) begin
      wr_q <= hsel_i && htrans_i[1] && hwrite_i;
      rd_q <= hsel_i && htrans_i[1] && !hwrite_i;
      idx_q <= haddr_i[9:2];
    end
  end
  sequence s_enable_off;
    wr_q && ((idx_q == IDX_BLOCK_IRQ_EN && !hwdata_i[0]) ||
      (idx_q == IDX_IRQ_EN && hwdata_i[4:0] == 5'h00));
  endsequence
  sequence s_m23;
    (ds3_mode_i && !cbit_parity_i) [*3];
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_CBIT_DRIVE:
    assert property (ds3_mode_i && cbit_parity_i |=> tx_alarm_drive_o) else $error("no drive");
  AST_NAT_DRIVE:
    assert property (!ds3_mode_i && national_bit_source_sel_i == NSEL_ALARM_TX
      |=> tx_alarm_drive_o) else $error("no national drive");
  AST_NAT_QUIET:
    assert property (!ds3_mode_i && national_bit_source_sel_i != NSEL_ALARM_TX
      |=> !tx_alarm_drive_o) else $error("national drive unselected");
  AST_M23_QUIET:
    assert property (ds3_mode_i && !cbit_parity_i |=> !tx_alarm_drive_o) else $error("m23 drive");
  AST_M23_ONES:
    assert property (s_m23 |-> tx_alarm_bit_o) else $error("m23 not ones");
  AST_BIT_AT_SLOT:
    assert property ($changed(tx_alarm_bit_o) |-> $past(tx_slot_i) || $past(tx_slot_i, 2))
      else $error("bit moved without slot");
  AST_IRQ_DROP:
    assert property (s_enable_off |-> ##[1:3] !alarm_irq_o) else $error("irq stayed");
  AST_FIFO_WIDTH:
    assert property (rd_q && idx_q == IDX_RX_FIFO |-> hrdata_o[31:6] == 26'h0)
      else $error("fifo read too wide");
endmodule : alarm_codeword_assertions

bind far_end_alarm_codeword_ctrl alarm_codeword_assertions i_alarm_codeword_assertions (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .ds3_mode_i(ds3_mode_i), .cbit_parity_i(cbit_parity_i),
  .national_bit_source_sel_i(national_bit_source_sel_i), .tx_slot_i(tx_slot_i),
  .tx_alarm_bit_o(tx_alarm_bit_o), .tx_alarm_drive_o(tx_alarm_drive_o),
  .alarm_irq_o(alarm_irq_o));

/* File: test/alarm_far_end_model.sv */
`timescale 1ns/1ps
module alarm_far_end_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tx_bit_i,
  input wire logic [6:0] rx_word_i,
  output logic tx_slot_o,
  output logic rx_slot_o,
  output logic rx_bit_o,
  output logic [15:0] tx_seen_o
);
  logic [1:0] div_q;
  logic [3:0] pos_q;
  logic [15:0] cw_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_q <= 2'h0;
      pos_q <= 4'h0;
      cw_q <= 16'hffff;
      tx_slot_o <= 1'b0;
      rx_slot_o <= 1'b0;
      rx_bit_o <= 1'b1;
      tx_seen_o <= 16'hffff;
    end else begin
      div_q <= div_q + 2'h1;
      tx_slot_o <= (div_q == 2'h3);
      rx_slot_o <= (div_q == 2'h3);
      // Collect the bit taken in each slot, first bit ends lowest
      if (tx_slot_o) begin
        tx_seen_o <= {tx_bit_i, tx_seen_o[15:1]};
      end
      if (div_q == 2'h3) begin
        rx_bit_o <= cw_q[pos_q];
        pos_q <= pos_q + 4'h1;
        // New word only on a codeword boundary
        if (pos_q == 4'hf) begin
          cw_q <= rx_word_i[6] ? {1'b0, rx_word_i[5:0], 1'b0, 8'hff} : 16'hffff;
        end
      end else begin
        rx_bit_o <= ~rx_bit_o;
      end
    end
  end
endmodule : alarm_far_end_model

/* File: test/far_end_alarm_codeword_ctrl_tb.sv */
`timescale 1ns/1ps
module far_end_alarm_codeword_ctrl_tb;
  import alarm_codeword_pkg::*;
  localparam logic [5:0] WORD_A = 6'h2d;
  localparam logic [5:0] WORD_B = 6'h13;
  logic ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, ds3_mode, cbit_parity;
  logic tx_slot, tx_bit, tx_drive, rx_slot, rx_bit, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, nsel;
  logic [2:0] hsize;
  logic [6:0] rx_word;
  logic [15:0] tx_seen;
  int failures, checks, cnt_a, cnt_b;
  logic [5:0] pay [5] = '{6'h01, 6'h12, 6'h2d, 6'h3e, 6'h07};
  logic [4:0] modes [4] = '{5'b10010, 5'b00001, 5'b01000, 5'b11100};
  far_end_alarm_codeword_ctrl i_far_end_alarm_codeword_ctrl (.ref_clk_i(ref_clk),
    .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .ds3_mode_i(ds3_mode),
    .cbit_parity_i(cbit_parity), .national_bit_source_sel_i(nsel), .tx_slot_i(tx_slot),
    .tx_alarm_bit_o(tx_bit), .tx_alarm_drive_o(tx_drive), .rx_slot_i(rx_slot),
    .rx_alarm_bit_i(rx_bit), .alarm_irq_o(irq));
  alarm_far_end_model i_alarm_far_end_model (.clk_i(ref_clk), .rst_n_i(rst_n),
    .tx_bit_i(tx_bit), .rx_word_i(rx_word), .tx_slot_o(tx_slot), .rx_slot_o(rx_slot),
    .rx_bit_o(rx_bit), .tx_seen_o(tx_seen));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge ref_clk);
    do begin
      bus(IDX_LIVE, 1'b0, 8'h00);
      n++;
    end while (rd[LIVE_TX_IDLE] !== 1'b1 && n < 1500);
  endtask : wait_idle
  task automatic finish_test();
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (tx_slot === 1'b1 && tx_seen === {1'b0, WORD_A, 1'b0, 8'hff}) cnt_a++;
    if (tx_slot === 1'b1 && tx_seen === {1'b0, WORD_B, 1'b0, 8'hff}) cnt_b++;
  end
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
  initial begin
    {rst_n, hsel, haddr, htrans, hwrite, hsize, hwdata} = {2'b01, 32'h0, 3'h0, 3'h2, 32'h0};
    {ds3_mode, cbit_parity, nsel, rx_word} = {4'hc, 7'h00};
    {failures, checks, cnt_a, cnt_b} = '0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    bus(IDX_LIVE, 1'b0, 8'h00);
    chk(rd, 32'h9);
    chk(hresp, 32'h0);
    bus(8'h70, 1'b1, 8'hff);
    bus(8'h70, 1'b0, 8'h00);
    chk(rd, 32'h0);
    // Alarm bit drive in each framer mode
    for (int i = 0; i < 4; i++) begin
      {ds3_mode, cbit_parity, nsel} <= modes[i][3:0];
      repeat (4) @(posedge ref_clk);
      chk(tx_drive, modes[i][4]);
    end
    bus(IDX_TX_FIRST, 1'b1, {2'h0, WORD_A});
    bus(IDX_TX_SECOND, 1'b1, {2'h0, WORD_B});
    bus(IDX_IRQ_EN, 1'b1, 8'h01);
    // Transmit actions: once, pair, continuous
    for (int s = 1; s < 4; s++) begin
      cnt_a = 0;
      cnt_b = 0;
      bus(IDX_CONTROL, 1'b1, 8'(s));
      repeat (4) @(posedge ref_clk);
      bus(IDX_LIVE, 1'b0, 8'h00);
      chk(rd[0], 1'b0);
      if (s == 2) bus(IDX_CONTROL, 1'b1, 8'h00);
      if (s == 3) begin
        repeat (1400) @(posedge ref_clk);
        bus(IDX_LIVE, 1'b0, 8'h00);
        chk(rd[0], 1'b0);
        bus(IDX_CONTROL, 1'b1, 8'h00);
      end
      wait_idle();
      // Sixteen idle slots must pass before the window holds only ones
      repeat (70) @(posedge ref_clk);
      chk(tx_seen, 32'hffff);
      chk(cnt_a >= 21 ? 21 : cnt_a, s == 3 ? 21 : 10);
      chk(cnt_b, s == 2 ? 10 : 0);
      chk(irq, s > 1);
      if (s == 1) begin
        bus(IDX_CONTROL, 1'b1, 8'h02);
        repeat (8) @(posedge ref_clk);
        bus(IDX_LIVE, 1'b0, 8'h00);
        chk(rd[0], 1'b1);
        bus(IDX_CONTROL, 1'b1, 8'h00);
        bus(IDX_BLOCK_IRQ_EN, 1'b1, 8'h01);
      end
      bus(IDX_LATCHED, 1'b0, 8'h00);
      chk(rd[0], 1'b1);
      bus(IDX_LATCHED, 1'b1, 8'h01);
      repeat (3) @(posedge ref_clk);
      chk(irq, 1'b0);
      bus(IDX_LATCHED, 1'b0, 8'h00);
      chk(rd[0], 1'b0);
    end
    bus(IDX_BLOCK_IRQ_EN, 1'b1, 8'h00);
    // Five codewords into a four-deep queue
    for (int i = 0; i < 5; i++) begin
      rx_word <= {1'b1, pay[i]};
      repeat (400) @(posedge ref_clk);
      if (i == 0) bus(IDX_LIVE, 1'b0, 8'h00);
      if (i == 0) chk(rd, 32'h3);
      if (i == 0) bus(IDX_LATCHED, 1'b1, 8'h02);
      // A new word must first clear detected, so the latch sets again
      if (i == 1) bus(IDX_LATCHED, 1'b0, 8'h00);
      if (i == 1) chk(rd[1], 1'b1);
    end
    rx_word <= 7'h00;
    repeat (200) @(posedge ref_clk);
    bus(IDX_LIVE, 1'b0, 8'h00);
    chk(rd, 32'h7);
    bus(IDX_LATCHED, 1'b0, 8'h00);
    chk(rd[4:1], 4'hf);
    for (int i = 0; i < 5; i++) begin
      bus(IDX_RX_FIFO, 1'b0, 8'h00);
      chk(rd, i < 4 ? {26'h0, pay[i]} : 32'h0);
    end
    bus(IDX_LIVE, 1'b0, 8'h00);
    chk(rd[3], 1'b1);
    // E3 framing: receiver listens on the national bit
    {ds3_mode, cbit_parity} <= 2'b00;
    rx_word <= {1'b1, pay[0]};
    repeat (400) @(posedge ref_clk);
    bus(IDX_LIVE, 1'b0, 8'h00);
    chk(rd[3], 1'b0);
    bus(IDX_CONTROL, 1'b1, 8'h04);
    bus(IDX_CONTROL, 1'b1, 8'h00);
    repeat (4) @(posedge ref_clk);
    bus(IDX_LIVE, 1'b0, 8'h00);
    chk(rd[3], 1'b1);
    finish_test();
  end
endmodule : far_end_alarm_codeword_ctrl_tb
